// File: design/disp_host_pkg.sv
// constants and carrier types for the display host port
// How it works
// R1 - two straps pick serial, enable-style or strobe-style parallel port
// R2 - while reset_n_in is low all port state except the pin synchronisers is initialised
// R3 - all bus activity is ignored unless chip select is low
// R4 - enable-style: enable going high with select low starts an access
// R5 - enable-style: direction high means read, low means write
// R6 - strobe-style: low read strobe with select low starts a read
// R7 - strobe-style: low write strobe with select low starts a write
// R8 - data/command high sends the byte to display memory
// R9 - data/command low sends the byte to the command register
// R10 - eight bit two-way data bus, driven only during reads
// R11 - serial mode: data bit one is serial data, bit zero serial clock
// R12 - reset clears the partial serial shift register
// R13 - reset clears the column counter and turns the display off
// R14 - serial bytes shift msb first on rising clock, eight edges per byte
// R15 - parallel writes latch data and selector at the strobe trailing edge
package disp_host_pkg;
   localparam int DATA_W = 8;
   localparam int COL_W = 7;
   localparam logic [COL_W-1:0] COL_RESET = 7'h00;
   localparam logic [COL_W-1:0] COL_LAST = 7'h5f;
   localparam logic [2:0] BIT_LAST = 3'h7;
   localparam int SERIAL_DATA_IN_BIT = 1;
   localparam int SCLK_BIT = 0;
   localparam logic [DATA_W-1:0] CMD_DISP_OFF = 8'hae;
   localparam logic [DATA_W-1:0] CMD_DISP_ON = 8'haf;

   typedef enum logic [2:0] {
      MODE_SERIAL = 3'b001,
      MODE_ENABLE = 3'b010,
      MODE_STROBE = 3'b100
   } mode_e;

   typedef struct packed {
      logic is_data;
      logic [DATA_W-1:0] value;
   } host_byte_s;
endpackage

// File: design/display_host_interface.sv
// host port of the display controller: two parallel styles and a serial port
`timescale 1ns/100ps
`default_nettype none
module display_host_interface
(
   // clock and reset
   input wire logic core_clk,
   input wire logic rst,
   // host pins
   input wire logic reset_n_in,
   input wire logic iface_strap_a,
   input wire logic iface_strap_b,
   input wire logic chip_sel_n,
   input wire logic enable_or_rd_n,
   input wire logic dir_or_wr_n,
   input wire logic data_cmd_sel,
   input wire logic [disp_host_pkg::DATA_W-1:0] host_data_in,
   output logic [disp_host_pkg::DATA_W-1:0] host_data_out,
   output logic host_data_oe,
   // core side
   output disp_host_pkg::host_byte_s wr_byte,
   output logic wr_valid,
   output logic rd_strobe,
   input wire logic [disp_host_pkg::DATA_W-1:0] rd_value,
   output logic [disp_host_pkg::COL_W-1:0] col_addr,
   output logic display_on,
   output logic port_in_reset
);
   // seven control pins plus the data bus
   localparam int NSYNC = 7 + disp_host_pkg::DATA_W;

   // two-stage synchronisers for all pins
   logic [NSYNC-1:0] s1_ff, s2_ff;
   always_ff @(posedge core_clk)
   begin
      if (rst)
      begin
         s1_ff <= '0;
         s2_ff <= '0;
      end
      else
      begin
         s1_ff <= {reset_n_in, iface_strap_a, iface_strap_b, chip_sel_n, enable_or_rd_n,
                   dir_or_wr_n, data_cmd_sel, host_data_in};
         s2_ff <= s1_ff;
      end
   end

   logic rn_s, sa_s, sb_s, cs_n_s, e_s, rw_s, dc_s;
   logic [disp_host_pkg::DATA_W-1:0] d_s;
   assign {rn_s, sa_s, sb_s, cs_n_s, e_s, rw_s, dc_s, d_s} = s2_ff;

   logic init;
   assign init = rst | ~rn_s; // [R2]
   assign port_in_reset = init;

   // mode from straps; the invalid a=1,b=0 falls back to serial
   disp_host_pkg::mode_e mode;
   always_comb
   begin
      case ({sa_s, sb_s}) // [R1]
         2'b01: mode = disp_host_pkg::MODE_ENABLE;
         2'b11: mode = disp_host_pkg::MODE_STROBE;
         default: mode = disp_host_pkg::MODE_SERIAL;
      endcase
   end

   // access-active levels per style
   logic sel, en_rd, en_wr, st_rd, st_wr, acc_rd, acc_wr;
   assign sel = ~cs_n_s; // [R3]
   assign en_rd = sel & e_s & rw_s; // [R4] [R5]
   assign en_wr = sel & e_s & ~rw_s; // [R4] [R5]
   assign st_rd = sel & ~e_s; // [R6]
   assign st_wr = sel & ~rw_s; // [R7]
   assign acc_rd = (mode == disp_host_pkg::MODE_ENABLE) ? en_rd :
                   (mode == disp_host_pkg::MODE_STROBE) ? st_rd : 1'b0;
   assign acc_wr = (mode == disp_host_pkg::MODE_ENABLE) ? en_wr :
                   (mode == disp_host_pkg::MODE_STROBE) ? st_wr : 1'b0;

   logic rd_ff, wr_ff, dc_hold_ff;
   logic [disp_host_pkg::DATA_W-1:0] d_hold_ff;
   always_ff @(posedge core_clk)
   begin
      if (init)
      begin
         rd_ff <= 1'b0;
         wr_ff <= 1'b0;
         d_hold_ff <= '0;
         dc_hold_ff <= 1'b0;
      end
      else
      begin
         rd_ff <= acc_rd;
         wr_ff <= acc_wr;
         if (acc_wr)
         begin
            d_hold_ff <= d_s;
            dc_hold_ff <= dc_s;
         end
      end
   end

   logic par_wr_done;
   assign par_wr_done = wr_ff & ~acc_wr; // [R15]
   assign rd_strobe = acc_rd & ~rd_ff;

   // serial receiver
   logic sclk_d_ff;
   logic [2:0] bit_cnt_ff;
   logic [disp_host_pkg::DATA_W-2:0] shift_ff;
   logic ser_rise, ser_done;
   assign ser_rise = (mode == disp_host_pkg::MODE_SERIAL) & sel
                     & d_s[disp_host_pkg::SCLK_BIT] & ~sclk_d_ff; // [R11] [R14]
   assign ser_done = ser_rise & (bit_cnt_ff == disp_host_pkg::BIT_LAST);
   always_ff @(posedge core_clk)
   begin
      if (init)
      begin
         sclk_d_ff <= 1'b0;
         bit_cnt_ff <= '0; // [R12]
         shift_ff <= '0; // [R12]
      end
      else
      begin
         sclk_d_ff <= d_s[disp_host_pkg::SCLK_BIT];
         if (!sel)
            bit_cnt_ff <= '0;
         else if (ser_rise)
         begin
            bit_cnt_ff <= bit_cnt_ff + 3'h1;
            shift_ff <= {shift_ff[disp_host_pkg::DATA_W-3:0], d_s[disp_host_pkg::SERIAL_DATA_IN_BIT]}; // [R14]
         end
      end
   end

   // byte output to the core
   disp_host_pkg::host_byte_s nxt_byte;
   always_comb
   begin
      nxt_byte.is_data = par_wr_done ? dc_hold_ff : dc_s; // [R8] [R9]
      nxt_byte.value = par_wr_done ? d_hold_ff : {shift_ff, d_s[disp_host_pkg::SERIAL_DATA_IN_BIT]};
   end

   always_ff @(posedge core_clk)
   begin
      if (init)
      begin
         wr_byte <= '0;
         wr_valid <= 1'b0;
      end
      else
      begin
         wr_valid <= par_wr_done | ser_done;
         if (par_wr_done | ser_done)
            wr_byte <= nxt_byte;
      end
   end

   // column counter and display on/off
   always_ff @(posedge core_clk)
   begin
      if (init)
      begin
         col_addr <= disp_host_pkg::COL_RESET; // [R13]
         display_on <= 1'b0; // [R13]
      end
      else if (wr_valid)
      begin
         if (wr_byte.is_data) // [R8]
            col_addr <= (col_addr == disp_host_pkg::COL_LAST) ? disp_host_pkg::COL_RESET : col_addr + 7'h01;
         else if (wr_byte.value == disp_host_pkg::CMD_DISP_ON) // [R9]
            display_on <= 1'b1;
         else if (wr_byte.value == disp_host_pkg::CMD_DISP_OFF)
            display_on <= 1'b0;
      end
   end

   // read data drive
   always_ff @(posedge core_clk)
   begin
      if (init)
      begin
         host_data_out <= '0;
         host_data_oe <= 1'b0;
      end
      else
      begin
         host_data_oe <= acc_rd; // [R10]
         if (rd_strobe)
            host_data_out <= rd_value;
      end
   end

   no_drive_idle_a: assert property (@(posedge core_clk) disable iff (rst)
      !acc_rd |=> !host_data_oe) else $error("bus driven outside read"); // [R10]
   no_sel_no_wr_a: assert property (@(posedge core_clk) disable iff (rst)
      cs_n_s |-> !acc_wr && !acc_rd) else $error("access while deselected"); // [R3]
   init_clear_a: assert property (@(posedge core_clk) disable iff (rst)
      !rn_s |=> col_addr == '0 && !display_on && bit_cnt_ff == '0) else $error("reset state wrong"); // [R13]
   wr_trail_a: assert property (@(posedge core_clk) disable iff (rst)
      $fell(wr_ff) && !$past(init) |-> ##0 wr_valid) else $error("write not issued at trailing edge"); // [R15]
   ser_byte_a: assert property (@(posedge core_clk) disable iff (init)
      ser_done |=> wr_valid && wr_byte.value[0] == $past(d_s[1])) else $error("serial byte lost"); // [R14]
   col_step_a: assert property (@(posedge core_clk) disable iff (init)
      wr_valid && wr_byte.is_data && col_addr != disp_host_pkg::COL_LAST |=> col_addr == $past(col_addr) + 7'h01)
      else $error("column did not advance"); // [R8]
   cmd_on_a: assert property (@(posedge core_clk) disable iff (init)
      wr_valid && !wr_byte.is_data && wr_byte.value == disp_host_pkg::CMD_DISP_ON |=> display_on)
      else $error("display on command ignored"); // [R9]
   en_read_a: assert property (@(posedge core_clk) disable iff (init)
      mode == disp_host_pkg::MODE_ENABLE && sel && e_s && rw_s |=> host_data_oe)
      else $error("enable-style read not driven"); // [R5]
   strobe_read_a: assert property (@(posedge core_clk) disable iff (init)
      mode == disp_host_pkg::MODE_STROBE && sel && !e_s |=> host_data_oe)
      else $error("strobe read not driven"); // [R6]
   serial_no_par_a: assert property (@(posedge core_clk) disable iff (init)
      mode == disp_host_pkg::MODE_SERIAL |-> !acc_wr && !acc_rd) else $error("parallel access in serial"); // [R1]
   strobe_wr_a: assert property (@(posedge core_clk) disable iff (init)
      mode == disp_host_pkg::MODE_STROBE && sel && !rw_s |-> acc_wr) else $error("strobe write missed"); // [R7]
   en_wr_a: assert property (@(posedge core_clk) disable iff (init)
      mode == disp_host_pkg::MODE_ENABLE && sel && e_s && !rw_s |-> acc_wr) else $error("enable write missed"); // [R4]

   cov_par_wr: cover property (@(posedge core_clk) par_wr_done);
   cov_ser_byte: cover property (@(posedge core_clk) ser_done);
   cov_read: cover property (@(posedge core_clk) rd_strobe);
   cov_disp_on: cover property (@(posedge core_clk) $rose(display_on));
endmodule // display_host_interface
`default_nettype wire

// File: bench/host_bus_model.sv
// host bus master model driving the display port pins
`timescale 1ns/100ps
`default_nettype none
module host_bus_model
(
   // clock
   input wire logic core_clk,
   // host pins
   output logic chip_sel_n,
   output logic enable_or_rd_n,
   output logic dir_or_wr_n,
   output logic data_cmd_sel,
   output logic [7:0] drv,
   input wire logic [7:0] bus_in
);
   logic [7:0] rdata = 8'h00;
   initial {chip_sel_n, enable_or_rd_n, dir_or_wr_n, data_cmd_sel, drv} = 12'h800;
   task automatic cyc(input int n);
      repeat (n) @(posedge core_clk);
   endtask
   // st strobe-style, rd read, ns leaves select high
   task automatic xfer(input logic st, input logic rd, input logic dc, input logic [7:0] b, input logic ns);
      chip_sel_n <= ns;
      data_cmd_sel <= dc;
      drv <= rd ? ~b : b;
      enable_or_rd_n <= st;
      dir_or_wr_n <= st | rd;
      cyc(3);
      if (!st) enable_or_rd_n <= 1'b1;
      else if (rd) enable_or_rd_n <= 1'b0;
      else dir_or_wr_n <= 1'b0;
      cyc(8);
      rdata = bus_in;
      enable_or_rd_n <= st;
      dir_or_wr_n <= st | rd;
      cyc(3);
      chip_sel_n <= 1'b1;
      drv <= ~drv;
      cyc(3);
   endtask
   // a short frame keeps select low
   task automatic ser(input logic dc, input logic [7:0] b, input int nbits);
      chip_sel_n <= 1'b0;
      data_cmd_sel <= dc;
      drv <= 8'h00;
      cyc(4);
      for (int i = 7; i > 7 - nbits; i--)
      begin
         drv <= {6'h00, b[i], 1'b0};
         cyc(15);
         drv[0] <= 1'b1;
         cyc(16);
      end
      drv[0] <= 1'b0;
      cyc(4);
      if (nbits == 8)
      begin
         chip_sel_n <= 1'b1;
         drv <= ~drv;
         cyc(3);
      end
   endtask
endmodule // host_bus_model
`default_nettype wire

// File: bench/test_display_host_interface.sv
// self-checking bench for the display host port
`timescale 1ns/100ps
`default_nettype none
module test_display_host_interface;
   logic core_clk = 1'b0, rst = 1'b1, reset_n_in = 1'b1, strap_a = 1'b0, strap_b = 1'b0;
   logic cs_n, en_rd, dir_wr, dc, oe, wr_valid, port_in_reset, display_on, rd_pulse;
   logic [7:0] drv, bus, data_out;
   logic [7:0] rd_value = 8'h5a;
   logic [disp_host_pkg::COL_W-1:0] col_addr;
   disp_host_pkg::host_byte_s wr_byte, last;
   int mismatches = 0, compares = 0, n_wr = 0, n_rd = 0, cycles = 0;
   always #2 core_clk = ~core_clk;
   assign bus = oe ? data_out : drv;
   host_bus_model hm (.core_clk(core_clk), .chip_sel_n(cs_n), .enable_or_rd_n(en_rd), .dir_or_wr_n(dir_wr),
      .data_cmd_sel(dc), .drv(drv), .bus_in(bus));
   display_host_interface u_dut (.core_clk(core_clk), .rst(rst), .reset_n_in(reset_n_in),
      .iface_strap_a(strap_a), .iface_strap_b(strap_b), .chip_sel_n(cs_n), .enable_or_rd_n(en_rd),
      .dir_or_wr_n(dir_wr), .data_cmd_sel(dc), .host_data_in(bus), .host_data_out(data_out),
      .host_data_oe(oe), .wr_byte(wr_byte), .wr_valid(wr_valid), .rd_strobe(rd_pulse), .rd_value(rd_value),
      .col_addr(col_addr), .display_on(display_on), .port_in_reset(port_in_reset));
   task automatic give_verdict;
      if (mismatches == 0 && compares > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   always @(posedge core_clk)
   begin
      cycles <= cycles + 1;
      if (wr_valid)
      begin
         last <= wr_byte;
         n_wr <= n_wr + 1;
      end
      if (rd_pulse)
         n_rd <= n_rd + 1;
      if (cycles == 5000)
      begin
         mismatches++;
         give_verdict();
      end
   end
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      compares++;
      if (got !== exp)
      begin
         mismatches++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic mode(input logic a, input logic b);
      strap_a <= a;
      strap_b <= b;
      hm.cyc(4);
   endtask
   task automatic t_reset;
      chk(col_addr, 7'h00);
      chk(display_on, 1'b0);
      chk(port_in_reset, 1'b0);
   endtask
   task automatic t_enable;
      mode(1'b0, 1'b1);
      hm.xfer(1'b0, 1'b0, 1'b0, 8'haf, 1'b0);
      chk(last, 9'h0af);
      chk(display_on, 1'b1);
      hm.xfer(1'b0, 1'b1, 1'b0, 8'h00, 1'b0);
      chk(hm.rdata, 8'h5a);
      chk(16'(n_rd), 16'h0001);
      chk(16'(n_wr), 16'h0001);
   endtask
   task automatic t_strobe;
      mode(1'b1, 1'b1);
      hm.xfer(1'b1, 1'b0, 1'b1, 8'h3c, 1'b0);
      chk(last, 9'h13c);
      chk(col_addr, 7'h01);
      rd_value <= 8'hc3;
      hm.xfer(1'b1, 1'b1, 1'b0, 8'h00, 1'b0);
      chk(hm.rdata, 8'hc3);
      chk(16'(n_rd), 16'h0002);
      chk(oe, 1'b0);
      hm.xfer(1'b1, 1'b0, 1'b0, 8'hae, 1'b1);
      chk(16'(n_wr), 16'h0002);
      chk(display_on, 1'b1);
      hm.xfer(1'b1, 1'b0, 1'b0, 8'hae, 1'b0);
      chk(last, 9'h0ae);
      chk(display_on, 1'b0);
      hm.xfer(1'b1, 1'b0, 1'b0, 8'haf, 1'b0);
      chk(16'(n_wr), 16'h0004);
      chk(display_on, 1'b1);
   endtask
   task automatic t_serial;
      mode(1'b1, 1'b0);
      hm.ser(1'b1, 8'h96, 8);
      chk(last, 9'h196);
      hm.ser(1'b1, 8'hff, 4);
      reset_n_in <= 1'b0;
      hm.cyc(8);
      chk(col_addr, 7'h00);
      chk(display_on, 1'b0);
      reset_n_in <= 1'b1;
      hm.cyc(8);
      mode(1'b0, 1'b0);
      hm.ser(1'b0, 8'h5c, 8);
      chk(last, 9'h05c);
   endtask
   initial
   begin
      repeat (10) @(posedge core_clk);
      rst <= 1'b0;
      hm.cyc(6);
      t_reset();
      t_enable();
      t_strobe();
      t_serial();
      give_verdict();
   end
endmodule // test_display_host_interface
`default_nettype wire
